// ==== aid_pkg.sv ====
// Shared constants and carrier types for the oscillator frequency aiding unit
package aid_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned CODE_ACC_W = 17;
  localparam int unsigned CODE_AID_W = 31;
  localparam int unsigned CARR_ACC_W = 24;
  localparam int unsigned CARR_AID_W = 38;
  localparam int unsigned AID_FRAC_W = 6;
  localparam int unsigned OSC_W      = 32;
  localparam int unsigned DIV_W      = 19;
  localparam int unsigned TS_W       = 64;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned OFS_W      = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [OFS_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [OFS_W-1:0] OFS_SETTINGS  = 8'h04;
  localparam logic [OFS_W-1:0] OFS_CODE_ACC  = 8'h08;
  localparam logic [OFS_W-1:0] OFS_CODE_AID  = 8'h0C;
  localparam logic [OFS_W-1:0] OFS_CODE_OSC  = 8'h10;
  localparam logic [OFS_W-1:0] OFS_CODE_SW   = 8'h14;
  localparam logic [OFS_W-1:0] OFS_CARR_ACC  = 8'h18;
  localparam logic [OFS_W-1:0] OFS_CARR_AID  = 8'h1C;
  localparam logic [OFS_W-1:0] OFS_CARR_OSC  = 8'h20;
  localparam logic [OFS_W-1:0] OFS_CARR_SW   = 8'h24;
  localparam logic [OFS_W-1:0] OFS_TS_UPPER  = 8'h28;
  localparam logic [OFS_W-1:0] OFS_TS_LOWER  = 8'h2C;
  localparam logic [OFS_W-1:0] OFS_STATUS    = 8'h30;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_CODE_EN_BIT  = 0;
  localparam int unsigned CTRL_CARR_EN_BIT  = 1;
  localparam int unsigned CTRL_TRIG_LSB     = 2;
  localparam int unsigned CTRL_DIV_LSB      = 8;
  localparam int unsigned SET_CODE_MODE_BIT = 0;
  localparam int unsigned SET_CARR_MODE_BIT = 1;
  localparam int unsigned ST_CODE_EN_BIT    = 0;
  localparam int unsigned ST_CARR_EN_BIT    = 1;
  localparam int unsigned ST_ARMED_BIT      = 2;
  localparam int unsigned ST_PEND_LSB       = 3;

  // Reset value of the divider ratio
  localparam logic [DIV_W-1:0] DIV_RESET = 19'h0_0000;

  // ==========================================================================
  // Trigger source encoding
  typedef enum logic [1:0] {
    TRIG_MEAS_EPOCH = 2'h0,
    TRIG_PPS        = 2'h1,
    TRIG_EXTERNAL   = 2'h2,
    TRIG_NONE       = 2'h3
  } trig_sel_t;

  // ==========================================================================
  // AHB-Lite carriers
  typedef struct packed {
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic              hready;
  } ahb_req_t;

  typedef struct packed {
    logic              hreadyout;
    logic              hresp;
    logic [DATA_W-1:0] hrdata;
  } ahb_rsp_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Epoch pulses from the correlator channel
  typedef struct packed {
    logic integration_epoch;
    logic measurement_epoch;
    logic pps;
  } epoch_t;

  // Oscillator increments handed to the phase accumulators
  typedef struct packed {
    logic [OSC_W-1:0] code_inc;
    logic [OSC_W-1:0] carr_inc;
  } osc_inc_t;

endpackage : aid_pkg

// ==== trig_sync.sv ====
// Pin synchroniser with rising edge pulse for the external aiding trigger
`timescale 1ns/100ps
`default_nettype none
module trig_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Pin and event
  input  wire logic pin_in,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_state_t;

  sync_state_t s;
  sync_state_t nxt_s;

  // ==========================================================================
  // Three stages, change accepted once stages two and three agree
  always_comb begin
    nxt_s      = s;
    nxt_s.s1   = pin_in;
    nxt_s.s2   = s.s1;
    nxt_s.s3   = s.s2;
    nxt_s.rise = 1'b0;
    if (s.s2 == s.s3) begin
      nxt_s.level = s.s3;
      nxt_s.rise  = s.s3 & ~s.level; // One pulse per rising edge
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  assign rise = s.rise;

endmodule : trig_sync
`default_nettype wire

// ==== aid_unit.sv ====
// Code and carrier oscillator frequency aiding unit with AHB-Lite registers
//
// Contract
// - Each aiding tick adds the acceleration into the aiding frequency of each path whose enable is in force.
// - After accumulation the software frequency and, for a path whose enable is in force, the aiding frequency are summed into the oscillator frequency.
// - Aiding enable bits take effect only at the next integration epoch.
// - Acceleration and aiding frequency writes stay pending until the selected trigger.
// - Reads of acceleration and aiding frequency return the effective, not pending, value.
// - Software frequency writes apply at once or at the next integration epoch per mode bit.
// - At the first trigger after new values, the new aiding frequency is used without acceleration.
// - After that trigger the oscillator frequency follows the accumulated aiding on every tick.
// - A newly effective frequency reaches the phase accumulator two core clocks after its trigger.
// - An external pin trigger captures the measurement time counter into the timestamp registers.
// - Aiding frequencies are 31 and 38 bits, only upper bits written, low 6 bits cleared on write.
// - The aiding tick comes from a 19-bit programmable divider of the core clock.
// - Any aiding register write arms a divider reset carried out at the next selected trigger.
`timescale 1ns/100ps
`default_nettype none
module aid_unit (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // AHB-Lite slave
  input  wire aid_pkg::ahb_req_t ahb_req,
  output aid_pkg::ahb_rsp_t      ahb_rsp,
  // Epoch pulses and time base
  input  wire aid_pkg::epoch_t   epochs,
  input  wire logic [63:0]       measurement_time_counter,
  // External trigger pin
  input  wire logic              external_aiding_trigger,
  // Oscillator increments
  output aid_pkg::osc_inc_t      osc_inc,
  output logic                   aiding_tick
);
  import aid_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    // Control fields
    logic                  code_en;
    logic                  carr_en;
    trig_sel_t             trig_sel;
    logic [DIV_W-1:0]      div_ratio;
    logic                  code_mode;
    logic                  carr_mode;
    // Enables in force
    logic                  code_en_eff;
    logic                  carr_en_eff;
    // Code path
    logic [CODE_ACC_W-1:0] code_acc;
    logic [CODE_ACC_W-1:0] code_acc_pend;
    logic                  code_acc_new;
    logic [CODE_AID_W-1:0] code_aid;
    logic [CODE_AID_W-1:0] code_aid_pend;
    logic                  code_aid_new;
    // Carrier path
    logic [CARR_ACC_W-1:0] carr_acc;
    logic [CARR_ACC_W-1:0] carr_acc_pend;
    logic                  carr_acc_new;
    logic [CARR_AID_W-1:0] carr_aid;
    logic [CARR_AID_W-1:0] carr_aid_pend;
    logic                  carr_aid_new;
    // Frequency words
    logic [OSC_W-1:0]      code_sw;
    logic [OSC_W-1:0]      code_sw_eff;
    logic [OSC_W-1:0]      carr_sw;
    logic [OSC_W-1:0]      carr_sw_eff;
    logic [OSC_W-1:0]      code_osc;
    logic [OSC_W-1:0]      carr_osc;
    logic [OSC_W-1:0]      code_inc;
    logic [OSC_W-1:0]      carr_inc;
    // Divider and timestamp
    logic                  div_armed;
    logic [DIV_W-1:0]      div_cnt;
    logic                  tick;
    logic [TS_W-1:0]       ts;
    // Bus data phase
    logic                  wr_pend;
    logic                  rd_pend;
    logic                  rd_done;
    logic [OFS_W-1:0]      addr;
    logic [DATA_W-1:0]     rdata;
  } aid_state_t;

  localparam aid_state_t STATE_RESET = '{
    trig_sel:  TRIG_MEAS_EPOCH,
    div_ratio: DIV_RESET,
    default:   '0
  };

  aid_state_t s;
  aid_state_t nxt_s;

  logic ext_rise;

  // ==========================================================================
  // External trigger pin detection
  trig_sync u_trig_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pin_in  (external_aiding_trigger),
    .rise    (ext_rise)
  );

  // ==========================================================================
  // Combinational helpers
  logic                  trigger;
  logic                  div_hit;
  logic                  any_new;
  logic                  addr_ok;
  logic                  wr_now;
  logic [DATA_W-1:0]     read_word;
  logic [OSC_W-1:0]      code_aid_ext;
  logic [OSC_W-1:0]      carr_aid_ext;
  logic [CODE_AID_W-1:0] code_acc_ext;
  logic [CARR_AID_W-1:0] carr_acc_ext;
  logic [DATA_W-1:0]     ctrl_word;
  logic [DATA_W-1:0]     status_word;

  // Trigger source selection
  always_comb begin
    case (s.trig_sel)
      TRIG_MEAS_EPOCH: trigger = epochs.measurement_epoch;
      TRIG_PPS:        trigger = epochs.pps;
      TRIG_EXTERNAL:   trigger = ext_rise;
      // No source, nothing applies
      default:         trigger = 1'b0;
    endcase
  end

  // Divider terminal count and pending summary
  // Ratio N ticks every N+1 clocks
  assign div_hit = (s.div_cnt == s.div_ratio);
  assign any_new = s.code_acc_new | s.code_aid_new | s.carr_acc_new | s.carr_aid_new;

  // Integer parts of the aiding frequencies, sign extended
  // Fraction bits not summed
  assign code_aid_ext = OSC_W'($signed(s.code_aid[CODE_AID_W-1:AID_FRAC_W]));
  assign carr_aid_ext = OSC_W'($signed(s.carr_aid[CARR_AID_W-1:AID_FRAC_W]));
  assign code_acc_ext = CODE_AID_W'($signed(s.code_acc));
  assign carr_acc_ext = CARR_AID_W'($signed(s.carr_acc));

  // Packed control and status words
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_CODE_EN_BIT] = s.code_en;
    ctrl_word[CTRL_CARR_EN_BIT] = s.carr_en;
    ctrl_word[CTRL_TRIG_LSB +: 2] = s.trig_sel;
    ctrl_word[CTRL_DIV_LSB +: DIV_W] = s.div_ratio;
    status_word = '0;
    status_word[ST_CODE_EN_BIT] = s.code_en_eff;
    status_word[ST_CARR_EN_BIT] = s.carr_en_eff;
    status_word[ST_ARMED_BIT] = s.div_armed;
    status_word[ST_PEND_LSB +: 4] = {s.carr_aid_new, s.carr_acc_new,
                                     s.code_aid_new, s.code_acc_new};
  end

  // Read multiplexer, effective acceleration and aiding values, written control and software frequency values
  always_comb begin
    read_word = '0;
    case (s.addr)
      OFS_CTRL:     read_word = ctrl_word;
      OFS_SETTINGS: begin
        read_word[SET_CODE_MODE_BIT] = s.code_mode;
        read_word[SET_CARR_MODE_BIT] = s.carr_mode;
      end
      OFS_CODE_ACC: read_word = DATA_W'(s.code_acc);
      OFS_CODE_AID: read_word = DATA_W'(s.code_aid[CODE_AID_W-1:AID_FRAC_W]);
      OFS_CODE_OSC: read_word = s.code_osc;
      OFS_CODE_SW:  read_word = s.code_sw;
      OFS_CARR_ACC: read_word = DATA_W'(s.carr_acc);
      OFS_CARR_AID: read_word = s.carr_aid[CARR_AID_W-1:AID_FRAC_W];
      OFS_CARR_OSC: read_word = s.carr_osc;
      OFS_CARR_SW:  read_word = s.carr_sw;
      OFS_TS_UPPER: read_word = s.ts[TS_W-1:DATA_W];
      OFS_TS_LOWER: read_word = s.ts[DATA_W-1:0];
      OFS_STATUS:   read_word = status_word;
      default:      read_word = '0;
    endcase
  end

  // Write happens in the data phase of an accepted write
  assign wr_now  = s.wr_pend;
  // Accepted address phase
  assign addr_ok = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_s      = s;
    nxt_s.tick = 1'b0;

    // Aiding clock divider, re-aligned by an armed trigger
    if (trigger && s.div_armed) begin
      nxt_s.div_cnt   = '0;
      nxt_s.div_armed = 1'b0;
    end else if (div_hit) begin
      nxt_s.div_cnt = '0;
      nxt_s.tick    = 1'b1;
    end else begin
      nxt_s.div_cnt = DIV_W'(s.div_cnt + 1'b1);
    end

    // Loading wins over a tick
    // Trigger applies pending values, no acceleration on this step
    if (trigger && any_new) begin
      if (s.code_acc_new) nxt_s.code_acc = s.code_acc_pend;
      if (s.code_aid_new) nxt_s.code_aid = s.code_aid_pend;
      if (s.carr_acc_new) nxt_s.carr_acc = s.carr_acc_pend;
      if (s.carr_aid_new) nxt_s.carr_aid = s.carr_aid_pend;
      // Pending flags cleared
      nxt_s.code_acc_new = 1'b0;
      nxt_s.code_aid_new = 1'b0;
      nxt_s.carr_acc_new = 1'b0;
      nxt_s.carr_aid_new = 1'b0;
    end else if (div_hit && !(trigger && s.div_armed)) begin
      // Acceleration accumulation on each aiding tick
      if (s.code_en_eff) nxt_s.code_aid = CODE_AID_W'(s.code_aid + code_acc_ext);
      if (s.carr_en_eff) nxt_s.carr_aid = CARR_AID_W'(s.carr_aid + carr_acc_ext);
    end

    // Timestamp when the pin is the active trigger
    // Last capture kept otherwise
    if (trigger && (s.trig_sel == TRIG_EXTERNAL)) begin
      nxt_s.ts = measurement_time_counter;
    end

    // Integration epoch takes enables and deferred software frequencies
    // Mode 1 waits for this epoch
    if (epochs.integration_epoch) begin
      nxt_s.code_en_eff = s.code_en;
      nxt_s.carr_en_eff = s.carr_en;
      if (s.code_mode) nxt_s.code_sw_eff = s.code_sw;
      if (s.carr_mode) nxt_s.carr_sw_eff = s.carr_sw;
    end

    // Oscillator sum, then one more stage to the phase accumulator
    // Disabled path drops aiding
    nxt_s.code_osc = OSC_W'(s.code_sw_eff + (s.code_en_eff ? code_aid_ext : '0));
    nxt_s.carr_osc = OSC_W'(s.carr_sw_eff + (s.carr_en_eff ? carr_aid_ext : '0));
    nxt_s.code_inc = s.code_osc;
    nxt_s.carr_inc = s.carr_osc;

    // Register writes, after trigger handling so a new write stays pending
    if (wr_now) begin
      case (s.addr)
        // Enables, source, divider
        OFS_CTRL: begin
          nxt_s.code_en   = ahb_req.hwdata[CTRL_CODE_EN_BIT];
          nxt_s.carr_en   = ahb_req.hwdata[CTRL_CARR_EN_BIT];
          nxt_s.trig_sel  = trig_sel_t'(ahb_req.hwdata[CTRL_TRIG_LSB +: 2]);
          nxt_s.div_ratio = ahb_req.hwdata[CTRL_DIV_LSB +: DIV_W];
        end
        // Update modes
        OFS_SETTINGS: begin
          nxt_s.code_mode = ahb_req.hwdata[SET_CODE_MODE_BIT];
          nxt_s.carr_mode = ahb_req.hwdata[SET_CARR_MODE_BIT];
        end
        // Writes arm the divider reset
        OFS_CODE_ACC: begin
          nxt_s.code_acc_pend = ahb_req.hwdata[CODE_ACC_W-1:0];
          nxt_s.code_acc_new  = 1'b1;
          nxt_s.div_armed     = 1'b1;
        end
        // Low fraction bits cleared
        OFS_CODE_AID: begin
          nxt_s.code_aid_pend = {ahb_req.hwdata[CODE_AID_W-AID_FRAC_W-1:0],
                                 AID_FRAC_W'(0)};
          nxt_s.code_aid_new  = 1'b1;
          nxt_s.div_armed     = 1'b1;
        end
        // Mode 0 applies at once
        OFS_CODE_SW: begin
          nxt_s.code_sw = ahb_req.hwdata;
          if (!s.code_mode) nxt_s.code_sw_eff = ahb_req.hwdata;
        end
        // Carrier mirrors code
        OFS_CARR_ACC: begin
          nxt_s.carr_acc_pend = ahb_req.hwdata[CARR_ACC_W-1:0];
          nxt_s.carr_acc_new  = 1'b1;
          nxt_s.div_armed     = 1'b1;
        end
        OFS_CARR_AID: begin
          nxt_s.carr_aid_pend = {ahb_req.hwdata[CARR_AID_W-AID_FRAC_W-1:0],
                                 AID_FRAC_W'(0)};
          nxt_s.carr_aid_new  = 1'b1;
          nxt_s.div_armed     = 1'b1;
        end
        OFS_CARR_SW: begin
          nxt_s.carr_sw = ahb_req.hwdata;
          if (!s.carr_mode) nxt_s.carr_sw_eff = ahb_req.hwdata;
        end
        default: begin
        end
      endcase
    end

    // Bus data phase bookkeeping
    // Write data phase lasts one cycle, read data phase two
    nxt_s.wr_pend = 1'b0;
    if (s.rd_pend && !s.rd_done) begin
      // Wait state: sample register contents after any earlier write
      nxt_s.rdata   = read_word;
      nxt_s.rd_done = 1'b1;
    end else begin
      nxt_s.rd_pend = 1'b0;
      nxt_s.rd_done = 1'b0;
      if (addr_ok) begin
        nxt_s.addr    = ahb_req.haddr[OFS_W-1:0];
        nxt_s.wr_pend = ahb_req.hwrite;
        nxt_s.rd_pend = ~ahb_req.hwrite;
      end
    end
  end

  // ==========================================================================
  // State register
  // Async reset to constants
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= STATE_RESET;
    end else begin
      s <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs
  // Wait state covers read after write
  assign ahb_rsp.hreadyout = ~(s.rd_pend & ~s.rd_done); // Reads take one wait state
  assign ahb_rsp.hresp     = HRESP_OKAY;
  assign ahb_rsp.hrdata    = s.rdata;
  assign osc_inc.code_inc  = s.code_inc;
  assign osc_inc.carr_inc  = s.carr_inc;
  assign aiding_tick       = s.tick;

endmodule : aid_unit
`default_nettype wire

// ==== aid_unit_asserts.sv ====
// Port-level assertions for the aiding unit
`timescale 1ns/100ps
`default_nettype none
module aid_unit_asserts (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // Register bus
  input wire aid_pkg::ahb_req_t ahb_req,
  input wire aid_pkg::ahb_rsp_t ahb_rsp,
  // Epochs, time base and pin
  input wire aid_pkg::epoch_t   epochs,
  input wire logic [63:0]       measurement_time_counter,
  input wire logic              external_aiding_trigger,
  // Oscillator side
  input wire aid_pkg::osc_inc_t osc_inc,
  input wire logic              aiding_tick
);
  import aid_pkg::*;
  // ==================================================================
  // Helper logic
  logic       acc;
  logic       acc_rd;
  logic       acc_wr;
  logic       cause;
  logic       wr_dp_ff;
  logic       rd_dp_ff;
  logic [3:0] quiet_ff;
  // Accepted transfers and anything that may move the increments
  assign acc    = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ);
  assign acc_rd = acc & ~ahb_req.hwrite;
  assign acc_wr = acc & ahb_req.hwrite;
  assign cause  = wr_dp_ff | (|epochs) | aiding_tick | external_aiding_trigger;
  // Data phase flags and count of quiet cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_dp_ff <= 1'b0;
      rd_dp_ff <= 1'b0;
      quiet_ff <= 4'h0;
    end else begin
      wr_dp_ff <= acc_wr;
      rd_dp_ff <= acc_rd;
      if (cause) begin
        quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hF) begin
        quiet_ff <= quiet_ff + 4'h1;
      end
    end
  end
  // ==================================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_resp_okay;
    ahb_rsp.hresp == HRESP_OKAY;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus response not okay");
  property p_read_wait;
    acc_rd |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_nowait;
    acc_wr |=> ahb_rsp.hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write was stalled");
  property p_wait_cause;
    $fell(ahb_rsp.hreadyout) |-> $past(acc_rd);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stall without a read");
  property p_rdata_stands;
    $changed(ahb_rsp.hrdata) |-> rd_dp_ff || $past(rd_dp_ff);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
  property p_inc_quiet;
    (quiet_ff >= 4'h8) |-> $stable(osc_inc);
  endproperty
  a_inc_quiet: assert property (p_inc_quiet) else $error("increment moved unprompted");
  property p_inc_delay;
    (quiet_ff >= 4'h8) && epochs.measurement_epoch |=> $stable(osc_inc);
  endproperty
  a_inc_delay: assert property (p_inc_delay) else $error("increment moved too early");
  property p_tick_start;
    $rose(arst_n) |-> !aiding_tick ##1 aiding_tick;
  endproperty
  a_tick_start: assert property (p_tick_start) else $error("tick wrong after reset");
endmodule : aid_unit_asserts
`default_nettype wire

// ==== ext_trig_src.sv ====
// Behavioural external trigger source for the aiding pin
`timescale 1ns/100ps
`default_nettype none
module ext_trig_src (
  // Clock
  input  wire logic clk_sys,
  // Trigger pin
  output var logic  pin_out
);
  // Pin idles low between pulses
  initial pin_out = 1'b0;
  // One pulse, never shorter than four core clocks
  task automatic hold(input int unsigned cycles);
    @(posedge clk_sys);
    pin_out <= 1'b1;
    repeat ((cycles < 4) ? 4 : cycles) @(posedge clk_sys);
    pin_out <= 1'b0;
  endtask : hold
endmodule : ext_trig_src
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the aiding unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import aid_pkg::*;
  // ==================================================================
  // Signals and design
  localparam epoch_t EP_IE  = 3'h4;
  localparam epoch_t EP_ME  = 3'h2;
  localparam epoch_t EP_PPS = 3'h1;
  logic        clk_sys;
  logic        arst_n;
  ahb_req_t    req_d;
  ahb_req_t    ahb_req;
  ahb_rsp_t    ahb_rsp;
  epoch_t      epochs;
  logic [63:0] time_base;
  logic        trig_pin;
  osc_inc_t    osc_inc;
  logic        aiding_tick;
  logic [31:0] rd;
  int          errors;
  int          checks_done;
  int          tick_gap;
  // Core clock
  always #5 clk_sys = ~clk_sys;
  // Single slave, so bus hready is our hreadyout
  always_comb begin
    ahb_req        = req_d;
    ahb_req.hready = ahb_rsp.hreadyout;
  end
  // Design and trigger source
  aid_unit dut (
    .clk_sys                  (clk_sys),
    .arst_n                   (arst_n),
    .ahb_req                  (ahb_req),
    .ahb_rsp                  (ahb_rsp),
    .epochs                   (epochs),
    .measurement_time_counter (time_base),
    .external_aiding_trigger  (trig_pin),
    .osc_inc                  (osc_inc),
    .aiding_tick              (aiding_tick)
  );
  ext_trig_src u_trig (
    .clk_sys (clk_sys),
    .pin_out (trig_pin)
  );
  // ==================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_ready();
    do begin
      @(posedge clk_sys);
    end while (ahb_rsp.hreadyout !== 1'b1);
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    req_d.hsel   <= 1'b1;
    req_d.haddr  <= {24'h00_0000, a};
    req_d.htrans <= HTRANS_NONSEQ;
    req_d.hwrite <= wr;
    wait_ready();
    req_d.hsel   <= 1'b0;
    req_d.htrans <= 2'h0;
    req_d.hwdata <= wd;
    wait_ready();
    rd = ahb_rsp.hrdata;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask : rc
  task automatic pulse(input epoch_t e);
    @(posedge clk_sys);
    epochs <= e;
    @(posedge clk_sys);
    epochs <= '0;
  endtask : pulse
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (aiding_tick !== 1'b1);
    @(posedge clk_sys);
  endtask : wait_tick
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // ==================================================================
  // Tests
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    req_d = '0;
    req_d.hsize = 3'h2;
    epochs = '0;
    time_base = 64'h0;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values, unmapped and read-only places
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rc(8'h40, 32'h0000_0000, "unmapped");
    bus(1'b1, OFS_CODE_OSC, 32'hFFFF_FFFF);
    rc(OFS_CODE_OSC, 32'h0000_0000, "code osc");
    $display("test reset done");
    // Software frequency, immediate and at integration epoch
    bus(1'b1, OFS_CTRL, 32'h0000_3100);
    bus(1'b1, OFS_SETTINGS, 32'h0000_0002);
    bus(1'b1, OFS_CODE_SW, 32'h0000_0100);
    bus(1'b1, OFS_CARR_SW, 32'h0000_0200);
    rc(OFS_CODE_OSC, 32'h0000_0100, "code osc");
    rc(OFS_CARR_OSC, 32'h0000_0000, "carr osc");
    chk("code inc", osc_inc.code_inc, 32'h0000_0100);
    pulse(EP_IE);
    @(posedge clk_sys);
    #1;
    chk("carr inc", osc_inc.carr_inc, 32'h0000_0000);
    @(posedge clk_sys);
    #1;
    chk("carr inc", osc_inc.carr_inc, 32'h0000_0200);
    rc(OFS_CARR_OSC, 32'h0000_0200, "carr osc");
    $display("test software frequency done");
    // Enables, pending aiding values, first trigger and ticks
    bus(1'b1, OFS_CTRL, 32'h0000_3103);
    rc(OFS_STATUS, 32'h0000_0000, "status");
    pulse(EP_IE);
    rc(OFS_STATUS, 32'h0000_0003, "status");
    bus(1'b1, OFS_CODE_AID, 32'h0000_0005);
    bus(1'b1, OFS_CODE_ACC, 32'h0000_0020);
    bus(1'b1, OFS_CARR_AID, 32'h0000_0003);
    bus(1'b1, OFS_CARR_ACC, 32'h0000_0080);
    rc(OFS_CODE_AID, 32'h0000_0000, "code aid");
    rc(OFS_CARR_ACC, 32'h0000_0000, "carr acc");
    repeat (10) @(posedge clk_sys);
    pulse(EP_ME);
    rc(OFS_CODE_OSC, 32'h0000_0105, "code osc");
    rc(OFS_CARR_OSC, 32'h0000_0203, "carr osc");
    rc(OFS_CODE_AID, 32'h0000_0005, "code aid");
    rc(OFS_CARR_ACC, 32'h0000_0080, "carr acc");
    wait_tick(tick_gap);
    wait_tick(tick_gap);
    chk("tick gap", tick_gap, 32'h0000_0031);
    rc(OFS_CODE_OSC, 32'h0000_0106, "code osc");
    rc(OFS_CARR_OSC, 32'h0000_0207, "carr osc");
    $display("test aiding done");
    // Trigger sources: pulse, external pin and none
    bus(1'b1, OFS_CTRL, 32'h0000_3107);
    bus(1'b1, OFS_CODE_AID, 32'hFFFF_FFFF);
    bus(1'b1, OFS_CODE_ACC, 32'h0000_0000);
    pulse(EP_ME);
    rc(OFS_CODE_ACC, 32'h0000_0020, "code acc");
    pulse(EP_PPS);
    rc(OFS_CODE_ACC, 32'h0000_0000, "code acc");
    rc(OFS_CODE_AID, 32'h01FF_FFFF, "code aid");
    rc(OFS_CODE_OSC, 32'h0000_00FF, "code osc");
    bus(1'b1, OFS_CTRL, 32'h0000_310B);
    bus(1'b1, OFS_CODE_ACC, 32'h0001_2345);
    time_base <= 64'h0123_4567_89AB_CDEF;
    pulse(EP_PPS);
    rc(OFS_CODE_ACC, 32'h0000_0000, "code acc");
    u_trig.hold(4);
    repeat (8) @(posedge clk_sys);
    rc(OFS_CODE_ACC, 32'h0001_2345, "code acc");
    rc(OFS_TS_UPPER, 32'h0123_4567, "ts upper");
    rc(OFS_TS_LOWER, 32'h89AB_CDEF, "ts lower");
    fork
      u_trig.hold(30);
      begin
        repeat (12) @(posedge clk_sys);
        bus(1'b1, OFS_CODE_ACC, 32'h0000_0055);
      end
    join
    repeat (8) @(posedge clk_sys);
    rc(OFS_CODE_ACC, 32'h0001_2345, "code acc");
    bus(1'b1, OFS_CTRL, 32'h0000_310F);
    pulse(EP_ME);
    pulse(EP_PPS);
    u_trig.hold(6);
    repeat (8) @(posedge clk_sys);
    rc(OFS_CODE_ACC, 32'h0001_2345, "code acc");
    $display("test trigger sources done");
    // Disabling code aiding waits for the integration epoch
    bus(1'b1, OFS_CTRL, 32'h0000_310E);
    rc(OFS_STATUS, 32'h0000_000F, "status");
    pulse(EP_IE);
    rc(OFS_STATUS, 32'h0000_000E, "status");
    rc(OFS_CODE_OSC, 32'h0000_0100, "code osc");
    chk("code inc", osc_inc.code_inc, 32'h0000_0100);
    bus(1'b1, OFS_SETTINGS, 32'h0000_0001);
    bus(1'b1, OFS_CODE_SW, 32'h0000_0300);
    rc(OFS_CODE_OSC, 32'h0000_0100, "code osc");
    pulse(EP_IE);
    rc(OFS_CODE_OSC, 32'h0000_0300, "code osc");
    $display("test disable done");
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
endmodule : tb_top
bind aid_unit aid_unit_asserts u_chk (
  .clk_sys                  (clk_sys),
  .arst_n                   (arst_n),
  .ahb_req                  (ahb_req),
  .ahb_rsp                  (ahb_rsp),
  .epochs                   (epochs),
  .measurement_time_counter (measurement_time_counter),
  .external_aiding_trigger  (external_aiding_trigger),
  .osc_inc                  (osc_inc),
  .aiding_tick              (aiding_tick)
);
`default_nettype wire
